// ---- logic/hrx_pkg.sv ----
// package of constants and types for the hdlc receive unit
package hrx_pkg;
  // register offsets
  localparam logic [7:0] HRX_CFG_ADDR = 8'hC0;
  localparam logic [7:0] HRX_IRQ_CTRL_ADDR = 8'hC1;
  localparam logic [7:0] HRX_STATUS_ADDR = 8'hC2;
  localparam logic [7:0] HRX_DATA_ADDR = 8'hC3;
  localparam logic [7:0] HRX_FIRST_MATCH_ADDR = 8'hC4;
  localparam logic [7:0] HRX_SECOND_MATCH_ADDR = 8'hC5;
  // reset values
  localparam logic [7:0] HRX_IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] HRX_MATCH_RST = 8'hFF;
  localparam logic [3:0] HRX_CFG_RST = 4'h0;
  // field positions
  localparam int HRX_CFG_EN_BIT = 0;
  localparam int HRX_CFG_TR_BIT = 1;
  localparam int HRX_CFG_MM_BIT = 2;
  localparam int HRX_CFG_MEN_BIT = 3;
  localparam int HRX_IRQ_ALLOW_BIT = 7;
  // fifo geometry
  localparam int HRX_FIFO_DEPTH = 128;
  localparam int HRX_PTR_W = 7;
  localparam logic [7:0] HRX_FILL_ZERO_AS = 8'h80;
  // serial patterns and masks
  localparam logic [7:0] HRX_FLAG_PAT = 8'h7E;
  localparam logic [7:0] HRX_ABORT_PAT = 8'hFE;
  localparam logic [6:0] HRX_ONES7 = 7'h7F;
  localparam logic [7:0] HRX_ALL_ONES = 8'hFF;
  localparam logic [7:0] HRX_MASK_LOW2 = 8'hFC;
  localparam logic [7:0] HRX_MASK_NONE = 8'hFF;
  localparam logic [15:0] HRX_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] HRX_CRC_GOOD = 16'hF0B8;
  localparam logic [15:0] HRX_CRC_POLY = 16'h8408;
  // byte status codes
  typedef enum logic [2:0] {
    HRX_BS_PLAIN = 3'h0,
    HRX_BS_LINK_UP = 3'h1,
    HRX_BS_LINK_DOWN = 3'h2,
    HRX_BS_RESERVED = 3'h3,
    HRX_BS_END_GOOD = 3'h4,
    HRX_BS_PARTIAL = 3'h5,
    HRX_BS_END_CRC = 3'h6,
    HRX_BS_END_CRC_PARTIAL = 3'h7
  } hrx_bs_t;
  // one fifo entry: status code plus data
  typedef struct packed {
    hrx_bs_t code;
    logic [7:0] data;
  } hrx_entry_t;
endpackage : hrx_pkg

// ---- logic/hrx_wr_if.sv ----
// write channel between the receiver and the fifo
`timescale 1ns/1ns
`default_nettype none
interface hrx_wr_if;
  import hrx_pkg::*;
  logic push;
  hrx_entry_t entry;
  logic overrun;
  modport src (output push, output entry, input overrun);
  modport dst (input push, input entry, output overrun);
endinterface : hrx_wr_if
`default_nettype wire

// ---- logic/hrx_fifo.sv ----
// 128 entry receive fifo with overrun detect
`timescale 1ns/1ns
`default_nettype none
module hrx_fifo (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  hrx_wr_if.dst wr,
  input wire logic pop,
  output var hrx_pkg::hrx_entry_t head,
  output logic empty,
  output logic [7:0] level
);
  import hrx_pkg::*;
  hrx_entry_t mem [HRX_FIFO_DEPTH];
  logic [HRX_PTR_W-1:0] wr_ptr;
  logic [HRX_PTR_W-1:0] rd_ptr;
  logic [7:0] count;
  wire full = (count == 8'(HRX_FIFO_DEPTH));
  wire do_pop = pop && (count != 8'h00);
  wire do_push = wr.push && !full;
  assign wr.overrun = wr.push && full;
  assign head = mem[rd_ptr];
  assign empty = (count == 8'h00);
  assign level = count;
  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= 8'h00;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= 8'h00;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 7'h01;
      if (do_pop) rd_ptr <= rd_ptr + 7'h01;
      count <= count + {7'h00, do_push} - {7'h00, do_pop};
    end
  end
  // storage
  always_ff @(posedge clk) begin
    if (do_push && !flush) mem[wr_ptr] <= wr.entry;
  end
endmodule : hrx_fifo
`default_nettype wire

// ---- logic/hrx_top.sv ----
// hdlc receive unit: deframer, address filter, fifo and registers
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module hrx_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic rx_bit_clk,
  input wire logic rx_data,
  output logic irq_out_n
);
  import hrx_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // functions
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] ref_b, input logic [7:0] msk);
    addr_hit = ((rx & msk) == (ref_b & msk));
  endfunction
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c[0] ^ b) ? ((c >> 1) ^ HRX_CRC_POLY) : (c >> 1);
  endfunction
  // whole byte, lsb first; taken only as bytes complete so flag bits stay out
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] acc;
    acc = c;
    for (int i = 0; i < $bits(b); i++) acc = crc_step(acc, b[i]);
    crc_byte = acc;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
    end else begin
      clk_s1 <= rx_bit_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= rx_data;
      dat_s2 <= dat_s1;
    end
  end
  wire bit_take = clk_s2 && !clk_s3;

  //////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] cfg;
  logic [7:0] irq_ctrl;
  logic [7:0] first_match_byte;
  logic [7:0] second_match_byte;
  logic overflow_flag, link_change_flag, packet_done_flag, fill_hit;
  hrx_bs_t byte_status_code;
  wire rx_enable = cfg[HRX_CFG_EN_BIT];
  wire address_mask_mode = cfg[HRX_CFG_MM_BIT];
  wire address_filter_on = cfg[HRX_CFG_MEN_BIT];
  wire irq_allow = irq_ctrl[HRX_IRQ_ALLOW_BIT];
  wire [7:0] irq_fill_threshold = (irq_ctrl[6:0] == 7'h00) ? HRX_FILL_ZERO_AS : {1'b0, irq_ctrl[6:0]};
  wire wr_cfg = wr_stb && (addr == HRX_CFG_ADDR);
  wire status_rd = rd_stb && (addr == HRX_STATUS_ADDR);
  wire data_rd = rd_stb && (addr == HRX_DATA_ADDR);
  wire terminate = wr_cfg && wdata[HRX_CFG_TR_BIT];
  // receiver and fifo held in reset while disabled, terminated or overflowed
  wire rx_hold = !rx_enable || terminate || overflow_flag;

  // config writes; terminate bit self clears
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= HRX_CFG_RST;
      irq_ctrl <= HRX_IRQ_CTRL_RST;
      first_match_byte <= HRX_MATCH_RST;
      second_match_byte <= HRX_MATCH_RST;
    end else begin
      if (wr_cfg) cfg <= {wdata[3:2], 1'b0, wdata[0]};
      if (wr_stb && addr == HRX_IRQ_CTRL_ADDR) irq_ctrl <= wdata;
      if (wr_stb && addr == HRX_FIRST_MATCH_ADDR) first_match_byte <= wdata;
      if (wr_stb && addr == HRX_SECOND_MATCH_ADDR) second_match_byte <= wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // deframer
  typedef enum logic [2:0] {
    HRX_HUNT = 3'b001,
    HRX_FIRST = 3'b010,
    HRX_BODY = 3'b100
  } hrx_state_t;
  hrx_state_t state;
  logic [7:0] shift;
  logic [7:0] dshift; // data bits only, stuffed zeros left out
  logic [2:0] ones;
  logic [2:0] bit_cnt;
  logic [7:0] hold_byte;
  logic hold_valid, link_up, keep_pkt;
  logic [15:0] crc;
  wire [7:0] next_shift = {dat_s2, shift[7:1]};
  wire is_flag = bit_take && (next_shift == HRX_FLAG_PAT);
  wire is_abort = bit_take && (next_shift[7:1] == HRX_ONES7) && shift[7] == 1'b1 && next_shift == HRX_ABORT_PAT;
  wire stuffed = bit_take && !dat_s2 && (ones == 3'h5);
  wire data_bit = bit_take && !stuffed && !is_flag && !is_abort && (state != HRX_HUNT);
  wire byte_done = data_bit && (bit_cnt == 3'h7);
  wire [7:0] rx_byte = {dat_s2, dshift[7:1]};
  wire [7:0] match_mask = address_mask_mode ? HRX_MASK_LOW2 : HRX_MASK_NONE;
  wire addr_ok = !address_filter_on || addr_hit(rx_byte, first_match_byte, match_mask)
    || addr_hit(rx_byte, second_match_byte, match_mask) || addr_hit(rx_byte, HRX_ALL_ONES, match_mask);
  wire crc_bad = (crc != HRX_CRC_GOOD);
  // the closing flag's first seven bits were counted as data, so whole bytes leave 7
  wire partial = (bit_cnt != 3'h7);
  wire pkt_end = is_flag && (state == HRX_BODY) && keep_pkt && hold_valid;
  wire [2:0] end_code = {1'b1, crc_bad, partial};

  // fifo write channel
  hrx_wr_if wr ();
  hrx_entry_t head;
  logic fifo_empty;
  logic [7:0] fifo_level;
  always_comb begin
    wr.push = 1'b0;
    wr.entry = '{code: HRX_BS_PLAIN, data: hold_byte};
    if (rx_hold) begin
      wr.push = 1'b0;
    end else if (is_flag && !link_up) begin
      wr.push = 1'b1;
      wr.entry = '{code: HRX_BS_LINK_UP, data: HRX_FLAG_PAT};
    end else if (is_abort && link_up) begin
      wr.push = 1'b1;
      wr.entry = '{code: HRX_BS_LINK_DOWN, data: HRX_ABORT_PAT};
    end else if (pkt_end) begin
      wr.push = 1'b1;
      wr.entry = '{code: hrx_bs_t'(end_code), data: hold_byte};
    end else if (byte_done && hold_valid && keep_pkt) begin
      wr.push = 1'b1;
    end
  end

  // deframer state, crc and held byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= HRX_HUNT;
      shift <= 8'h00;
      ones <= 3'h0;
      bit_cnt <= 3'h0;
      hold_byte <= 8'h00;
      hold_valid <= 1'b0;
      link_up <= 1'b0;
      keep_pkt <= 1'b0;
      dshift <= 8'h00;
      crc <= HRX_CRC_INIT;
    end else if (rx_hold) begin
      state <= HRX_HUNT;
      shift <= 8'h00;
      ones <= 3'h0;
      bit_cnt <= 3'h0;
      hold_valid <= 1'b0;
      link_up <= 1'b0;
      keep_pkt <= 1'b0;
      dshift <= 8'h00;
      crc <= HRX_CRC_INIT;
    end else if (bit_take) begin
      shift <= next_shift;
      ones <= dat_s2 ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
      if (is_flag) begin
        state <= HRX_FIRST;
        link_up <= 1'b1;
        bit_cnt <= 3'h0;
        hold_valid <= 1'b0;
        crc <= HRX_CRC_INIT;
      end else if (is_abort) begin
        state <= HRX_HUNT;
        link_up <= 1'b0;
        hold_valid <= 1'b0;
      end else if (data_bit) begin
        bit_cnt <= bit_cnt + 3'h1;
        dshift <= rx_byte;
        if (byte_done) begin
          hold_byte <= rx_byte;
          crc <= crc_byte(crc, rx_byte);
          hold_valid <= 1'b1;
          state <= HRX_BODY;
          if (state == HRX_FIRST) keep_pkt <= addr_ok;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // fifo
  hrx_fifo u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .flush(rx_hold),
    .wr(wr),
    .pop(data_rd),
    .head(head),
    .empty(fifo_empty),
    .level(fifo_level)
  );

  //////////////////////////////////////////////////////////////////////
  // status flags; a set in the read cycle wins over the clear
  wire fill_now = wr.push && !wr.overrun && (fifo_level + 8'h01 == irq_fill_threshold);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag <= 1'b0;
      link_change_flag <= 1'b0;
      packet_done_flag <= 1'b0;
      fill_hit <= 1'b0;
      byte_status_code <= HRX_BS_PLAIN;
    end else begin
      if (wr.overrun && !rx_hold) overflow_flag <= 1'b1;
      else if (status_rd) overflow_flag <= 1'b0;
      if (!rx_enable || overflow_flag) link_change_flag <= 1'b0;
      else if (wr.push && (wr.entry.code == HRX_BS_LINK_UP || wr.entry.code == HRX_BS_LINK_DOWN))
        link_change_flag <= 1'b1;
      else if (status_rd) link_change_flag <= 1'b0;
      if (rx_hold) packet_done_flag <= 1'b0;
      else if (pkt_end) packet_done_flag <= 1'b1;
      else if (status_rd) packet_done_flag <= 1'b0;
      if (rx_hold) fill_hit <= 1'b0;
      else if (fill_now) fill_hit <= 1'b1;
      else if (status_rd) fill_hit <= 1'b0;
      if (data_rd && !fifo_empty) byte_status_code <= head.code;
    end
  end

  wire irq_pending = overflow_flag || link_change_flag || packet_done_flag || fill_hit;
  assign irq_out_n = !(irq_pending && irq_allow);

  //////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      HRX_CFG_ADDR: next_rdata = {4'h0, cfg};
      HRX_IRQ_CTRL_ADDR: next_rdata = irq_ctrl;
      HRX_STATUS_ADDR: next_rdata = {fifo_empty, overflow_flag, link_change_flag, packet_done_flag,
        byte_status_code, irq_pending};
      HRX_DATA_ADDR: next_rdata = head.data;
      HRX_FIRST_MATCH_ADDR: next_rdata = first_match_byte;
      HRX_SECOND_MATCH_ADDR: next_rdata = second_match_byte;
      default: next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rdata <= 8'h00;
    else if (rd_stb) rdata <= next_rdata;
    else rdata <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////
  // assertions
  sequence ovr_event_s;
    wr.overrun && !rx_hold;
  endsequence
  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    !irq_allow |-> irq_out_n) else $error("irq output while not allowed");
  irq_pend_a: assert property (@(posedge clk) disable iff (!rst_b)
    (overflow_flag && irq_allow) |-> !irq_out_n) else $error("overflow not signalled");
  ovr_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    ovr_event_s |=> overflow_flag) else $error("overrun not flagged");
  ovr_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
    (overflow_flag && !status_rd) |=> overflow_flag) else $error("overflow dropped early");
  ovr_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    overflow_flag |=> (fifo_empty && !packet_done_flag)) else $error("fifo not held in reset");
  disable_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    !rx_enable |=> (fifo_empty && !link_change_flag)) else $error("disable did not clear");
  pkt_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pkt_end && !rx_hold) |=> packet_done_flag) else $error("packet done not set");
  pkt_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (status_rd && !pkt_end) |=> !packet_done_flag) else $error("packet done not cleared");
  link_up_a: assert property (@(posedge clk) disable iff (!rst_b)
    (is_flag && !link_up && !rx_hold) |-> (wr.push && wr.entry.code == HRX_BS_LINK_UP))
    else $error("no link dummy byte");
  empty_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wr.push && !rx_hold && fifo_empty) |=> !fifo_empty) else $error("empty after load");
  fill_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_ctrl[6:0] == 7'h00 && fifo_level == HRX_FILL_ZERO_AS - 8'h01 && wr.push && !wr.overrun && !rx_hold)
    |=> fill_hit) else $error("zero threshold wrong");
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !rd_stb |=> (rdata == 8'h00)) else $error("read data outside its cycle");
endmodule : hrx_top
`default_nettype wire

// ---- verification/hrx_link_model.sv ----
// serial hdlc bit stream source standing in for the framer
`timescale 1ns/1ns
`default_nettype none
module hrx_link_model (
  output logic bit_clk,
  output logic bit_data
);
  int ones;
  // clock and data idle, clock stands still outside frames
  initial begin
    bit_clk = 1'b0;
    bit_data = 1'b1;
    ones = 0;
  end
  // one bit per 400 ns, data set while clock low
  task automatic send_bit(input logic b);
    bit_data = b;
    #200 bit_clk = 1'b1;
    #200 bit_clk = 1'b0;
    bit_data = ~b; // held time over: show the inverse
  endtask
  // byte lsb first, zero insertion unless raw pattern
  task automatic send_byte(input logic [7:0] v, input bit raw);
    for (int i = 0; i < 8; i++) begin
      send_bit(v[i]);
      ones = (v[i] && !raw) ? ones + 1 : 0;
      if (ones == 5) begin
        send_bit(1'b0);
        ones = 0;
      end
    end
  endtask
endmodule // hrx_link_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the hdlc receive unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hrx_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, r, held, cfg, ictl, pa, sa;
  logic rx_bit_clk, rx_data, irq_out_n;
  logic [2:0] last = HRX_BS_PLAIN;
  logic [15:0] crc;
  logic [10:0] q[$];
  logic [31:0] seed = 32'd24003;
  int num_errors = 0;
  int total_checks = 0;
  bit up, held_v, keep, ovf, lc, pd, fill, first;
  always #25 clk = ~clk;
  hrx_top i_hrx_top (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .rx_bit_clk(rx_bit_clk), .rx_data(rx_data), .irq_out_n(irq_out_n));
  hrx_link_model i_hrx_link_model (.bit_clk(rx_bit_clk), .bit_data(rx_data));
  ////////////////////////////////////////////////////////////////
  // helpers: random, compare, register bus
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ HRX_CRC_POLY : c >> 1;
    return c;
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 r = rdata;
  endtask
  ////////////////////////////////////////////////////////////////
  // behavioural model of fifo, flags and receiver
  task automatic set_cfg(input logic [7:0] v);
    wr(HRX_CFG_ADDR, v);
    cfg = v;
    if (!v[0]) begin
      q.delete();
      {ovf, lc, pd, fill, up, held_v} = 6'h00;
    end
  endtask
  task automatic push(input logic [2:0] c, input logic [7:0] d);
    if (ovf) return;
    if (q.size() == HRX_FIFO_DEPTH) begin
      q.delete();
      {ovf, lc, pd, fill, up, held_v} = 6'h20;
      return;
    end
    q.push_back({c, d});
    if (q.size() == ((ictl[6:0] == 7'h00) ? 128 : int'(ictl[6:0]))) fill = 1;
    if (c[2]) pd = 1;
  endtask
  function automatic bit hit(input logic [7:0] b);
    logic [7:0] m = cfg[2] ? HRX_MASK_LOW2 : HRX_MASK_NONE;
    return ((b ^ pa) & m) == 0 || ((b ^ sa) & m) == 0 || ((b ^ HRX_ALL_ONES) & m) == 0;
  endfunction
  task automatic flag();
    i_hrx_link_model.send_byte(HRX_FLAG_PAT, 1);
    if (ovf || !cfg[0]) return;
    if (held_v && keep) push({1'b1, crc !== HRX_CRC_GOOD, 1'b0}, held);
    if (!up) begin
      push(HRX_BS_LINK_UP, HRX_FLAG_PAT);
      lc = !ovf;
      up = 1;
    end
    held_v = 0;
    first = 1;
    crc = HRX_CRC_INIT;
  endtask
  task automatic abort();
    i_hrx_link_model.send_byte(HRX_ABORT_PAT, 1);
    i_hrx_link_model.send_byte(HRX_ALL_ONES, 1);
    if (ovf || !cfg[0] || !up) return;
    push(HRX_BS_LINK_DOWN, 8'h00);
    lc = 1;
    up = 0;
    held_v = 0;
  endtask
  task automatic byte_in(input logic [7:0] b);
    i_hrx_link_model.send_byte(b, 0);
    if (ovf || !cfg[0] || !up) return;
    if (first) keep = !cfg[3] || hit(b);
    first = 0;
    crc = crc_step(crc, b);
    if (held_v && keep) push(HRX_BS_PLAIN, held);
    held = b;
    held_v = !ovf;
  endtask
  task automatic frame(input int n, input logic [7:0] b0, input bit bad, input bit close);
    logic [7:0] d[$];
    logic [15:0] c = HRX_CRC_INIT;
    d.push_back(b0);
    for (int i = 1; i < n; i++) d.push_back(rnd());
    foreach (d[i]) c = crc_step(c, d[i]);
    c = ~c ^ {15'h0000, bad};
    d.push_back(c[7:0]);
    d.push_back(c[15:8]);
    flag();
    foreach (d[i]) byte_in(d[i]);
    if (close) flag();
  endtask
  task automatic chk_status();
    logic [7:0] e;
    bit p;
    repeat (8) @(posedge clk);
    p = ovf | lc | pd | fill;
    cmp({7'h00, irq_out_n}, {7'h00, !(ictl[HRX_IRQ_ALLOW_BIT] && p)});
    e = {q.size() == 0, ovf, lc, pd, last, p};
    rd(HRX_STATUS_ADDR);
    cmp(r, e);
    {ovf, lc, pd, fill} = 4'h0;
  endtask
  task automatic drain();
    logic [10:0] e;
    while (q.size() > 0) begin
      e = q.pop_front();
      rd(HRX_DATA_ADDR);
      if (e[10:8] != HRX_BS_LINK_DOWN) cmp(r, e[7:0]);
      last = e[10:8];
      chk_status();
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    #4000000;
    num_errors++;
    summarize();
  end
  // main sequence
  initial begin
    {cfg, ictl, pa, sa} = {8'h00, 8'h00, 8'hFF, 8'hFF};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    cmp({7'h00, irq_out_n}, 8'h01);
    rd(HRX_IRQ_CTRL_ADDR);
    cmp(r, HRX_IRQ_CTRL_RST);
    rd(HRX_FIRST_MATCH_ADDR);
    cmp(r, HRX_MATCH_RST);
    rd(HRX_SECOND_MATCH_ADDR);
    cmp(r, HRX_MATCH_RST);
    wr(8'hC7, 8'h5A);
    rd(8'hC7);
    cmp(r, 8'h00);
    pa = rnd();
    sa = rnd();
    wr(HRX_FIRST_MATCH_ADDR, pa);
    wr(HRX_SECOND_MATCH_ADDR, sa);
    rd(HRX_FIRST_MATCH_ADDR);
    cmp(r, pa);
    rd(HRX_SECOND_MATCH_ADDR);
    cmp(r, sa);
    set_cfg(8'h06);
    rd(HRX_CFG_ADDR);
    cmp(r, 8'h04);
    $display("test 1 registers done");
    // good and bad crc packets, interrupt output held off
    set_cfg(8'h01);
    frame(3, rnd(), 0, 1);
    frame(2, rnd(), 1, 1);
    chk_status();
    drain();
    $display("test 2 packets done");
    // link down and up again with interrupt allowed
    set_cfg(8'h00);
    ictl = 8'h80;
    wr(HRX_IRQ_CTRL_ADDR, ictl);
    set_cfg(8'h01);
    abort();
    flag();
    abort();
    flag();
    chk_status();
    drain();
    $display("test 3 link state done");
    // address filter, plain and masked
    set_cfg(8'h09);
    frame(2, pa, 0, 1);
    frame(2, pa ^ 8'h01, 0, 1);
    frame(2, HRX_ALL_ONES, 0, 1);
    frame(2, sa, 0, 1);
    set_cfg(8'h0D);
    frame(2, pa ^ 8'h03, 0, 1);
    frame(2, pa ^ 8'h04, 0, 1);
    drain();
    $display("test 4 filter done");
    // fill level of five, then disable with data inside
    set_cfg(8'h00);
    ictl = 8'h85;
    wr(HRX_IRQ_CTRL_ADDR, ictl);
    set_cfg(8'h01);
    flag();
    drain();
    frame(4, rnd(), 0, 0);
    chk_status();
    set_cfg(8'h00);
    chk_status();
    $display("test 5 fill done");
    // threshold zero as 128, then overrun and recovery
    ictl = 8'h80;
    wr(HRX_IRQ_CTRL_ADDR, ictl);
    set_cfg(8'h01);
    flag();
    drain();
    frame(126, rnd(), 0, 0);
    chk_status();
    byte_in(rnd());
    chk_status();
    byte_in(rnd());
    byte_in(rnd());
    chk_status();
    chk_status();
    flag();
    drain();
    $display("test 6 overrun done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
